/* File: core/pwu_pkg.sv */
// package: constants and types of the periodic wake-up interval timer
package pwu_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_PRESCALE = 8'h38;
  localparam logic [7:0] ADDR_CTRL_STAT = 8'h39;
  localparam logic [7:0] ADDR_EVT_STAT = 8'h3C;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h3D;
  localparam logic [7:0] ADDR_CNT_STAT = 8'h3E;

  // field positions of wakeup_control_status
  localparam int FLAG_BIT = 7;
  localparam int ACK_BIT = 6;
  localparam int IVL_MSB = 5;

  // reset values, and the forced and off interval codes
  localparam logic [5:0] PRESCALE_POR = 6'h1F;
  localparam logic [5:0] INTERVAL_RST = 6'h3F;
  localparam logic [5:0] INTERVAL_FORCED = 6'h3F;
  localparam logic [5:0] INTERVAL_OFF = 6'h00;

  // prescale period = base + step * setting, in oscillator ticks
  localparam int PSC_W = 11;
  localparam logic [PSC_W-1:0] PSC_BASE = 11'h1F8;
  localparam int PSC_STEP_SHIFT = 4;

  // event status bits
  localparam int EVT_W = 3;
  localparam int EVT_WAKE = 0;
  localparam int EVT_RCLK = 1;
  localparam int EVT_REJECT = 2;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // thermal restart inputs
  typedef struct packed {
    logic restart_en;
    logic out_of_range;
  } thermal_t;

endpackage

/* File: core/pin_sync.sv */
// two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/100ps
module pin_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_sync
);

  logic stage1_reg;
  logic stage2_reg;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end else begin
      stage1_reg <= i_async;
      stage2_reg <= stage1_reg;
    end
  end

  assign o_sync = stage2_reg;

endmodule // pin_sync

/* File: core/wrap_counter.sv */
// up-counter that returns to zero on reaching a limit, with load and restart
`timescale 1ns/100ps
module wrap_counter #(
  parameter int W = 6
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_en,
  input wire logic i_clr,
  input wire logic i_load,
  input wire logic [W-1:0] i_load_val,
  input wire logic [W-1:0] i_limit,
  output logic [W-1:0] o_count,
  output logic o_wrap
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic [W-1:0] count_inc;
  logic at_limit;

  // advance, wrap to zero at limit
  assign count_inc = count_reg + {{(W-1){1'b0}}, 1'b1};
  assign at_limit = (count_inc == i_limit);
  assign o_wrap = i_en && !i_clr && !i_load && at_limit;
  assign count_next = i_load ? i_load_val :
                      i_clr ? '0 :
                      !i_en ? count_reg :
                      at_limit ? '0 : count_inc;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign o_count = count_reg;

endmodule // wrap_counter

/* File: core/periodic_wakeup_interval_timer.sv */
// periodic wake-up interval timer: prescaler, interval counter, flag, registers
`timescale 1ns/100ps
module periodic_wakeup_interval_timer (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_other_rst,
  input wire logic i_osc_tick,
  input wire pwu_pkg::reg_req_t i_req,
  input wire logic i_prst_interval_zero,
  input wire logic i_prst_due,
  input wire pwu_pkg::thermal_t i_thermal,
  output logic [7:0] o_rdata,
  output logic o_wakeup_irq,
  output logic o_rclk_pulse,
  output logic o_prst_clear_allowed,
  output logic o_irq
);

  // registers
  logic [5:0] prescale_setting_reg;
  logic [5:0] prescale_setting_next;
  logic [5:0] wakeup_interval_reg;
  logic [5:0] wakeup_interval_next;
  logic wakeup_flag_reg;
  logic wakeup_flag_next;
  logic [pwu_pkg::EVT_W-1:0] evt_stat_reg;
  logic [pwu_pkg::EVT_W-1:0] evt_stat_next;
  logic [pwu_pkg::EVT_W-1:0] evt_mask_reg;
  logic [pwu_pkg::EVT_W-1:0] evt_mask_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic tick_prev_reg;
  logic rclk_reg;
  logic allowed_reg;
  logic irq_reg;

  // synchronised oscillator input and its single-cycle enable
  logic tick_sync;
  logic tick_en;

  // register decode
  logic wr_psc;
  logic wr_cs;
  logic wr_evt;
  logic wr_mask;
  logic [5:0] wr_interval;
  logic interval_zero_req;
  logic interval_reject;
  logic interval_change;
  logic ack_write;

  // read views of each register
  logic [7:0] view_psc;
  logic [7:0] view_cs;
  logic [7:0] view_evt;
  logic [7:0] view_mask;
  logic [7:0] view_cnt;

  // counters
  logic [pwu_pkg::PSC_W-1:0] psc_period;
  logic [pwu_pkg::PSC_W-1:0] psc_count;
  logic [pwu_pkg::PSC_W-1:0] setting_wide;
  logic [pwu_pkg::PSC_W-1:0] psc_step;
  logic wclk_en;
  logic [5:0] ivl_count;
  logic ivl_wrap;
  logic restart;
  logic interval_off;
  logic force_load;
  logic wake_due;
  logic thermal_hold;
  logic wake_issue;
  logic [pwu_pkg::EVT_W-1:0] evt_set;

  // oscillator tick crosses into the clock domain
  pin_sync u_tick_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_osc_tick),
    .o_sync(tick_sync)
  );

  // rising edge of the synchronised tick gives one enable cycle
  assign tick_en = tick_sync && !tick_prev_reg;

  // address decode
  assign wr_psc = i_req.wr && (i_req.addr == pwu_pkg::ADDR_PRESCALE);
  assign wr_cs = i_req.wr && (i_req.addr == pwu_pkg::ADDR_CTRL_STAT);
  assign wr_evt = i_req.wr && (i_req.addr == pwu_pkg::ADDR_EVT_STAT);
  assign wr_mask = i_req.wr && (i_req.addr == pwu_pkg::ADDR_EVT_MASK);

  // interval write: reject a clear while the reset interval is already clear
  assign wr_interval = i_req.wdata[pwu_pkg::IVL_MSB:0];
  assign interval_zero_req = (wr_interval == pwu_pkg::INTERVAL_OFF);
  assign interval_reject = wr_cs && interval_zero_req && i_prst_interval_zero;
  assign interval_change = wr_cs && !interval_reject
                           && (wr_interval != wakeup_interval_reg);
  assign ack_write = wr_cs && i_req.wdata[pwu_pkg::ACK_BIT];

  // next register values
  assign prescale_setting_next = wr_psc ? i_req.wdata[5:0] : prescale_setting_reg;
  assign wakeup_interval_next = i_other_rst ? pwu_pkg::INTERVAL_RST :
                                interval_change ? wr_interval : wakeup_interval_reg;

  // prescale period in ticks: base plus sixteen per step; the setting is
  // widened first so the shifted step cannot lose its top bits
  assign setting_wide = {{(pwu_pkg::PSC_W - 6){1'b0}}, prescale_setting_reg};
  assign psc_step = setting_wide << pwu_pkg::PSC_STEP_SHIFT;
  assign psc_period = pwu_pkg::PSC_BASE + psc_step;

  // restart both counters on a changed interval or a non power-on reset
  assign restart = interval_change || i_other_rst;

  // prescaler counts ticks up to its period
  wrap_counter #(
    .W(pwu_pkg::PSC_W)
  ) u_prescaler (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_en(tick_en),
    .i_clr(restart),
    .i_load(1'b0),
    .i_load_val('0),
    .i_limit(psc_period),
    .o_count(psc_count),
    .o_wrap(wclk_en)
  );

  // a zero interval parks the interval counter at its top value
  assign interval_off = (wakeup_interval_reg == pwu_pkg::INTERVAL_OFF);
  assign force_load = interval_off && !restart;

  // interval counter counts prescaled periods, fires, returns to zero
  wrap_counter #(
    .W(6)
  ) u_interval (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_en(wclk_en),
    .i_clr(restart),
    .i_load(force_load),
    .i_load_val(pwu_pkg::INTERVAL_FORCED),
    .i_limit(wakeup_interval_reg),
    .o_count(ivl_count),
    .o_wrap(ivl_wrap)
  );

  // interrupt issue: due, not overtaken by a periodic reset, not held by thermal
  assign wake_due = ivl_wrap && !interval_off;
  assign thermal_hold = i_thermal.restart_en && i_thermal.out_of_range;
  assign wake_issue = wake_due && !i_prst_due && !thermal_hold;

  // flag: set wins over acknowledge, any reset clears it
  assign wakeup_flag_next = i_other_rst ? 1'b0 :
                            wake_issue ? 1'b1 :
                            ack_write ? 1'b0 : wakeup_flag_reg;

  // sticky event status, write one to clear, set wins
  assign evt_set = {interval_reject, wake_due, wake_issue};
  assign evt_stat_next = evt_set
                         | (evt_stat_reg & ~(wr_evt ? i_req.wdata[pwu_pkg::EVT_W-1:0] : '0));
  assign evt_mask_next = wr_mask ? i_req.wdata[pwu_pkg::EVT_W-1:0] : evt_mask_reg;

  // read views: unused upper bits and the acknowledge bit read zero
  assign view_psc = {2'b00, prescale_setting_reg};
  assign view_cs = {wakeup_flag_reg, 1'b0, wakeup_interval_reg};
  assign view_evt = {5'h00, evt_stat_reg};
  assign view_mask = {5'h00, evt_mask_reg};
  assign view_cnt = {2'b00, ivl_count};

  // read mux, nothing but zero outside a read cycle
  always_comb begin
    rdata_next = 8'h00;
    if (i_req.rd) begin
      case (i_req.addr)
        pwu_pkg::ADDR_PRESCALE: rdata_next = view_psc;
        pwu_pkg::ADDR_CTRL_STAT: rdata_next = view_cs;
        pwu_pkg::ADDR_EVT_STAT: rdata_next = view_evt;
        pwu_pkg::ADDR_EVT_MASK: rdata_next = view_mask;
        pwu_pkg::ADDR_CNT_STAT: rdata_next = view_cnt;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // divider setting: only power-on reset loads it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prescale_setting_reg <= pwu_pkg::PRESCALE_POR;
    end else begin
      prescale_setting_reg <= prescale_setting_next;
    end
  end

  // wake-up interval: every kind of reset presets it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wakeup_interval_reg <= pwu_pkg::INTERVAL_RST;
    end else begin
      wakeup_interval_reg <= wakeup_interval_next;
    end
  end

  // wake-up flag: sticky until acknowledge or reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wakeup_flag_reg <= 1'b0;
    end else begin
      wakeup_flag_reg <= wakeup_flag_next;
    end
  end

  // event status, write one to clear
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      evt_stat_reg <= '0;
    end else begin
      evt_stat_reg <= evt_stat_next;
    end
  end

  // event mask, only gates the summary interrupt
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      evt_mask_reg <= '0;
    end else begin
      evt_mask_reg <= evt_mask_next;
    end
  end

  // read data register, stands one cycle after the read strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // previous synchronised tick, idle low like the pin so reset gives no false edge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_prev_reg <= 1'b0;
    end else begin
      tick_prev_reg <= tick_sync;
    end
  end

  // periodic-reset clock, one pulse per completed period even when suppressed
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rclk_reg <= 1'b0;
    end else begin
      rclk_reg <= wake_due;
    end
  end

  // clear permission for the periodic-reset interval follows the interval
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      allowed_reg <= 1'b1;
    end else begin
      allowed_reg <= (wakeup_interval_next != pwu_pkg::INTERVAL_OFF);
    end
  end

  // summary interrupt from next state, so it does not lag a further cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(evt_stat_next & evt_mask_next);
    end
  end

  assign o_rdata = rdata_reg;
  assign o_wakeup_irq = wakeup_flag_reg;
  assign o_rclk_pulse = rclk_reg;
  assign o_prst_clear_allowed = allowed_reg;
  assign o_irq = irq_reg;

endmodule // periodic_wakeup_interval_timer

/* File: testbench/pwu_checker_asserts.sv */
// port-level assertions for the periodic wake-up interval timer
`timescale 1ns/100ps
module pwu_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_other_rst,
  input wire pwu_pkg::reg_req_t i_req,
  input wire logic i_prst_due,
  input wire pwu_pkg::thermal_t i_thermal,
  input wire logic [7:0] o_rdata,
  input wire logic o_wakeup_irq,
  input wire logic o_rclk_pulse,
  input wire logic o_prst_clear_allowed,
  input wire logic o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // control register accesses and suppression causes
  wire ctl_rd = i_req.rd && i_req.addr == pwu_pkg::ADDR_CTRL_STAT;
  wire ctl_wr = i_req.wr && i_req.addr == pwu_pkg::ADDR_CTRL_STAT;
  wire ack_wr = ctl_wr && i_req.wdata[pwu_pkg::ACK_BIT];
  wire supp = i_prst_due || (i_thermal.restart_en && i_thermal.out_of_range);
  ack_zero_a: assert property (ctl_rd |=> !o_rdata[pwu_pkg::ACK_BIT])
    else $error("acknowledge bit read as one");
  flag_cause_a: assert property ($rose(o_wakeup_irq) |-> o_rclk_pulse)
    else $error("flag rose without a period");
  flag_set_a: assert property ($rose(o_rclk_pulse) && !$past(supp) && !$past(i_other_rst)
    |-> o_wakeup_irq)
    else $error("period ended without flag");
  flag_hold_a: assert property (o_wakeup_irq && !ack_wr && !i_other_rst |=> o_wakeup_irq)
    else $error("flag dropped without acknowledge");
  ack_clear_a: assert property (ack_wr && !i_other_rst |=> !o_wakeup_irq || o_rclk_pulse)
    else $error("acknowledge did not clear flag");
  rclk_single_a: assert property (o_rclk_pulse |=> !o_rclk_pulse)
    else $error("period pulse longer than one cycle");
  other_rst_a: assert property (i_other_rst |=> !o_wakeup_irq)
    else $error("flag survived reset");
  clear_allow_a: assert property (ctl_wr && i_req.wdata[5:0] != 6'h00 && !i_other_rst
    |-> ##[1:2] o_prst_clear_allowed)
    else $error("clear not allowed with nonzero interval");
  cover property ($rose(o_wakeup_irq));
  cover property (o_rclk_pulse && !o_wakeup_irq);
  cover property ($rose(o_irq));
  cover property ($fell(o_prst_clear_allowed));
endmodule // pwu_checker

/* File: testbench/periodic_wakeup_interval_timer_tb_top.sv */
// self-checking bench for the periodic wake-up interval timer
`timescale 1ns/100ps
module periodic_wakeup_interval_timer_tb_top;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_other_rst = 1'b0;
  logic i_osc_tick = 1'b0;
  pwu_pkg::reg_req_t i_req = '0;
  logic i_prst_interval_zero = 1'b0;
  logic i_prst_due = 1'b0;
  pwu_pkg::thermal_t i_thermal = '0;
  logic [7:0] o_rdata;
  logic o_wakeup_irq;
  logic o_rclk_pulse;
  logic o_prst_clear_allowed;
  logic o_irq;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_rclk = 0;
  periodic_wakeup_interval_timer periodic_wakeup_interval_timer_inst (.i_clk(i_clk),
    .i_rst(i_rst), .i_other_rst(i_other_rst), .i_osc_tick(i_osc_tick), .i_req(i_req),
    .i_prst_interval_zero(i_prst_interval_zero), .i_prst_due(i_prst_due),
    .i_thermal(i_thermal), .o_rdata(o_rdata), .o_wakeup_irq(o_wakeup_irq),
    .o_rclk_pulse(o_rclk_pulse), .o_prst_clear_allowed(o_prst_clear_allowed), .o_irq(o_irq));
  // 100 MHz clock
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  // counts periodic-reset clock pulses
  always @(posedge i_clk) begin
    if (o_rclk_pulse === 1'b1) n_rclk++;
  end
  task automatic summarize();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_req.addr <= a;
    i_req.wdata <= d;
    i_req.wr <= 1'b1;
    @(posedge i_clk);
    i_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_req.addr <= a;
    i_req.rd <= 1'b1;
    @(posedge i_clk);
    i_req.rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // one oscillator tick every three clocks
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge i_clk);
      i_osc_tick <= 1'b1;
      @(posedge i_clk);
      i_osc_tick <= 1'b0;
      @(posedge i_clk);
    end
  endtask
  // flag must stay low one tick short of the period and show exp after it
  task automatic period(input int n, input logic [7:0] exp);
    ticks(n - 1);
    cyc(6);
    chk(8'(o_wakeup_irq), 8'h00);
    ticks(1);
    cyc(6);
    chk(8'(o_wakeup_irq), exp);
  endtask
  // watchdog, about three times the expected run of some 15000 clocks
  initial begin
    #500000;
    n_mismatch++;
    summarize();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(8'h38, 8'h1F);
    rd(8'h39, 8'h3F);
    chk(8'(o_prst_clear_allowed), 8'h01);
    wr(8'h38, 8'h00);
    wr(8'h39, 8'h01);
    period(504, 8'h01);
    chk(8'(n_rclk), 8'h01);
    wr(8'h39, 8'h01);
    rd(8'h39, 8'h81);
    wr(8'h39, 8'h41);
    rd(8'h39, 8'h01);
    wr(8'h39, 8'h81);
    rd(8'h39, 8'h01);
    wr(8'h38, 8'h01);
    period(520, 8'h01);
    wr(8'h39, 8'h41);
    i_thermal <= 2'b11;
    period(520, 8'h00);
    i_thermal <= 2'b00;
    i_prst_due <= 1'b1;
    period(520, 8'h00);
    i_prst_due <= 1'b0;
    chk(8'(n_rclk), 8'h04);
    wr(8'h3C, 8'h07);
    i_prst_interval_zero <= 1'b1;
    wr(8'h39, 8'h00);
    rd(8'h39, 8'h01);
    rd(8'h3C, 8'h04);
    chk(8'(o_irq), 8'h00);
    wr(8'h3D, 8'h04);
    cyc(2);
    chk(8'(o_irq), 8'h01);
    wr(8'h3C, 8'h04);
    cyc(2);
    chk(8'(o_irq), 8'h00);
    i_prst_interval_zero <= 1'b0;
    wr(8'h39, 8'h00);
    rd(8'h3E, 8'h3F);
    chk(8'(o_prst_clear_allowed), 8'h00);
    ticks(520);
    cyc(6);
    chk({o_wakeup_irq, 7'(n_rclk)}, 8'h04);
    @(posedge i_clk);
    i_other_rst <= 1'b1;
    @(posedge i_clk);
    i_other_rst <= 1'b0;
    rd(8'h39, 8'h3F);
    rd(8'h38, 8'h01);
    rd(8'h40, 8'h00);
    wr(8'h39, 8'h02);
    ticks(260);
    wr(8'h39, 8'h02);
    ticks(260);
    cyc(6);
    rd(8'h3E, 8'h01);
    ticks(300);
    wr(8'h39, 8'h03);
    rd(8'h3E, 8'h00);
    ticks(519);
    cyc(6);
    rd(8'h3E, 8'h00);
    ticks(1);
    cyc(6);
    rd(8'h3E, 8'h01);
    ticks(1040);
    cyc(6);
    rd(8'h3E, 8'h00);
    chk(8'(o_wakeup_irq), 8'h01);
    summarize();
  end
endmodule // periodic_wakeup_interval_timer_tb_top
bind periodic_wakeup_interval_timer pwu_checker pwu_checker_inst (.i_clk(i_clk),
  .i_rst(i_rst), .i_other_rst(i_other_rst), .i_req(i_req), .i_prst_due(i_prst_due),
  .i_thermal(i_thermal), .o_rdata(o_rdata), .o_wakeup_irq(o_wakeup_irq),
  .o_rclk_pulse(o_rclk_pulse), .o_prst_clear_allowed(o_prst_clear_allowed), .o_irq(o_irq));
